// >>> rtl/cvr_cmp_chan.sv
// Purpose: Synchronises one comparator output, applies polarity and routing.
// Assumes: The raw comparator level is asynchronous to core_clk.
// Notes: The result holds its last value while the comparator is off.
module cvr_cmp_chan
    import cvr_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic raw,
    cvr_cmp_if.chan_side cmp
);
    logic raw_s1_q;
    logic raw_s2_q;
    logic result_q;
    logic result_d;
    logic pin_out_q;
    logic pin_oe_n_q;

    // =====================================================================
    // Input synchroniser
    // =====================================================================
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            raw_s1_q <= 1'b1;
            raw_s2_q <= 1'b1;
        end else begin
            raw_s1_q <= raw;
            raw_s2_q <= raw_s1_q;
        end
    end

    // =====================================================================
    // Polarity and pin routing
    // =====================================================================
    always_comb begin
        result_d = cmp.on ? (raw_s2_q ^ ~cmp.noninvert) : result_q;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_q <= 1'b1;
        end else begin
            result_q <= result_d;
        end
    end

    // The pin is released while off so the port logic regains it.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out_q <= 1'b1;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_out_q <= result_d;
            pin_oe_n_q <= ~(cmp.on & ~cmp.route_n);
        end
    end

    assign cmp.result = result_q;
    assign cmp.pin_out = pin_out_q;
    assign cmp.pin_oe_n = pin_oe_n_q;

    a_result_polarity: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        cmp.on |=> result_q == ($past(raw_s2_q) ^ ~$past(cmp.noninvert)))
        else $error("comparator result polarity wrong");

    a_pin_route: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (cmp.on && !cmp.route_n) |=> (!pin_oe_n_q && pin_out_q == result_q))
        else $error("comparator result not driven on pin");
endmodule : cvr_cmp_chan

// >>> rtl/cvr_cmp_if.sv
// Purpose: Carries one comparator's control and conditioned output.
// Assumes: Control side and channel side share one clock.
// Notes: Channel outputs are all registered.
interface cvr_cmp_if;
    logic on;
    logic noninvert;
    logic route_n;
    logic result;
    logic pin_out;
    logic pin_oe_n;

    modport ctrl_side (
        output on,
        output noninvert,
        output route_n,
        input result,
        input pin_out,
        input pin_oe_n
    );

    modport chan_side (
        input on,
        input noninvert,
        input route_n,
        output result,
        output pin_out,
        output pin_oe_n
    );
endinterface : cvr_cmp_if

// >>> rtl/cvr_ctrl.sv
// Purpose: Registers and control for two comparators and a reference ladder.
// Assumes: Analog parts sit outside; raw comparator levels are asynchronous.
// Notes: Every output is registered, so effects lag a write by two cycles.
//
// Design decisions made here: strobed register access and the register offsets.
module cvr_ctrl
    import cvr_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic cmp_a_raw,
    input wire logic cmp_b_raw,
    output logic cmp_a_on,
    output logic cmp_b_on,
    output logic cmp_a_neg_pin_sel,
    output logic cmp_a_pos_pin_sel,
    output logic [1:0] cmp_b_pos_mux,
    output logic cmp_b_neg_pin_sel,
    output logic cmp_a_pin_out,
    output logic cmp_a_pin_oe_n,
    output logic cmp_b_pin_out,
    output logic cmp_b_pin_oe_n,
    output logic timer_cmp_select,
    output logic timer_cmp_clk,
    output logic [FORCE_W-1:0] pin_analog_force,
    output logic cmp_wake_set,
    output logic ladder_power_on,
    output logic ladder_pin_a_drive,
    output logic ladder_pin_b_drive,
    output logic ladder_low_range,
    output logic [LEVEL_W-1:0] ladder_level,
    output logic [CODE_W-1:0] ladder_code,
    output logic ladder_grounded
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic [DATA_W-2:0] ctrl_a_q;
    logic [DATA_W-2:0] ctrl_b_q;
    logic [DATA_W-1:0] ladder_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] snap_q;
    logic armed_q;
    logic wake_q;
    logic wake_d;
    logic rd_latch;
    logic a_on;
    logic b_on;
    logic a_change;
    logic b_change;
    logic a_en_q;
    logic b_en_q;
    logic a_neg_q;
    logic a_pos_q;
    logic b_neg_q;
    logic [1:0] b_mux_q;
    logic b_mux_alt;
    cvr_bpos_t b_mux_d;
    logic tsel_q;
    logic tclk_q;
    logic [FORCE_W-1:0] force_d;
    logic [FORCE_W-1:0] force_q;
    logic l_pow_q;
    logic l_pa_q;
    logic l_pb_q;
    logic l_low_q;
    logic [LEVEL_W-1:0] l_lvl_q;
    logic [CODE_W-1:0] l_code_q;
    logic [CODE_W-1:0] l_code_d;
    logic [CODE_W-1:0] l_lvl_w;
    logic l_gnd_q;

    cvr_cmp_if cmp_if_a ();
    cvr_cmp_if cmp_if_b ();

    // =====================================================================
    // Register file
    // =====================================================================
    // The result bit is not stored here; writes to bit 7 of either comparator register are dropped.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_a_q <= RST_CMP[DATA_W-2:0];
            ctrl_b_q <= RST_CMP[DATA_W-2:0];
            ladder_q <= RST_LADDER;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CMP_A) begin
                ctrl_a_q <= reg_wdata[DATA_W-2:0];
            end
            if (reg_addr == ADDR_CMP_B) begin
                ctrl_b_q <= reg_wdata[DATA_W-2:0];
            end
            if (reg_addr == ADDR_LADDER) begin
                ladder_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= RD_UNMAPPED;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CMP_A: rdata_q <= {cmp_if_a.result, ctrl_a_q};
                ADDR_CMP_B: rdata_q <= {cmp_if_b.result, ctrl_b_q};
                ADDR_LADDER: rdata_q <= ladder_q;
                default: rdata_q <= RD_UNMAPPED;
            endcase
        end else begin
            rdata_q <= RD_UNMAPPED;
        end
    end

    // =====================================================================
    // Comparator channels
    // =====================================================================
    assign a_on = ctrl_a_q[BIT_ON];
    assign b_on = ctrl_b_q[BIT_ON];

    assign cmp_if_a.on = a_on;
    assign cmp_if_a.noninvert = ctrl_a_q[BIT_NONINV];
    assign cmp_if_a.route_n = ctrl_a_q[BIT_ROUTE_N];
    assign cmp_if_b.on = b_on;
    assign cmp_if_b.noninvert = ctrl_b_q[BIT_NONINV];
    assign cmp_if_b.route_n = ctrl_b_q[BIT_ROUTE_N];

    cvr_cmp_chan u_chan_a (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .raw(cmp_a_raw),
        .cmp(cmp_if_a.chan_side)
    );

    cvr_cmp_chan u_chan_b (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .raw(cmp_b_raw),
        .cmp(cmp_if_b.chan_side)
    );

    // =====================================================================
    // Input multiplexer selects
    // =====================================================================
    // B's selects fall back to their reset values while B is off.
    assign b_mux_alt = ctrl_b_q[BIT_B_POS_ALT];

    always_comb begin
        if (!b_on || ctrl_b_q[BIT_POS_SEL]) begin
            b_mux_d = BPOS_OWN_PIN;
        end else if (b_mux_alt) begin
            b_mux_d = BPOS_A_POS_PIN;
        end else begin
            b_mux_d = BPOS_B_NEG_PIN;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            a_en_q <= 1'b1;
            b_en_q <= 1'b1;
            a_neg_q <= 1'b1;
            a_pos_q <= 1'b1;
            b_neg_q <= 1'b1;
            b_mux_q <= BPOS_OWN_PIN;
        end else begin
            a_en_q <= a_on;
            b_en_q <= b_on;
            a_neg_q <= ctrl_a_q[BIT_NEG_SEL];
            a_pos_q <= ctrl_a_q[BIT_POS_SEL];
            b_neg_q <= ~b_on | ctrl_b_q[BIT_NEG_SEL];
            b_mux_q <= b_mux_d;
        end
    end

    // =====================================================================
    // Analog pin overrides
    // =====================================================================
    // The analog-select register itself is never written here, so turning
    // a comparator off hands its pins back to the port settings, except A's positive pin while B on uses it.
    always_comb begin
        force_d = '0;
        force_d[FORCE_A_POS] = a_on & ctrl_a_q[BIT_POS_SEL];
        force_d[FORCE_A_NEG] = a_on & (ctrl_a_q[BIT_NEG_SEL] |
                                       ~ctrl_a_q[BIT_POS_SEL]);
        if (b_on) begin
            force_d[FORCE_B_POS] = ctrl_b_q[BIT_POS_SEL];
            force_d[FORCE_A_POS] = force_d[FORCE_A_POS] |
                (~ctrl_b_q[BIT_POS_SEL] & b_mux_alt);
            force_d[FORCE_B_NEG] = ctrl_b_q[BIT_NEG_SEL] |
                (~ctrl_b_q[BIT_POS_SEL] & ~b_mux_alt);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            force_q <= '0;
        end else begin
            force_q <= force_d;
        end
    end

    // =====================================================================
    // Timer clock source
    // =====================================================================
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tsel_q <= 1'b0;
            tclk_q <= 1'b1;
        end else begin
            tsel_q <= ~ctrl_a_q[BIT_A_TIMER_N];
            tclk_q <= cmp_if_a.result;
        end
    end

    // =====================================================================
    // Wake on change
    // =====================================================================
    // Reading either control register snapshots both results and arms the
    // detector. A hit disarms it, so one change gives a single pulse.
    assign rd_latch = reg_rd &&
        (reg_addr == ADDR_CMP_A || reg_addr == ADDR_CMP_B);
    assign a_change = a_on && !ctrl_a_q[BIT_WAKE_DIS] &&
        (cmp_if_a.result != snap_q[0]);
    assign b_change = b_on && !ctrl_b_q[BIT_WAKE_DIS] &&
        (cmp_if_b.result != snap_q[1]);
    assign wake_d = armed_q && (a_change || b_change);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            snap_q <= 2'h3;
            armed_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
            if (rd_latch) begin
                snap_q <= {cmp_if_b.result, cmp_if_a.result};
                armed_q <= 1'b1;
            end else if (wake_d) begin
                armed_q <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Reference ladder
    // =====================================================================
    // Code is the ladder voltage in 96ths of supply, the common denominator
    // of both ranges, so the analog side needs one tap decoder.
    assign l_lvl_w = {{(CODE_W-LEVEL_W){1'b0}}, ladder_q[LEVEL_W-1:0]};

    always_comb begin
        if (ladder_q[BIT_L_LOW]) begin
            l_code_d = l_lvl_w * LADDER_LOW_STEP;
        end else begin
            l_code_d = LADDER_HIGH_BASE + l_lvl_w * LADDER_HIGH_STEP;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            l_pow_q <= 1'b0;
            l_pa_q <= 1'b0;
            l_pb_q <= 1'b0;
            l_low_q <= 1'b1;
            l_lvl_q <= '1;
            l_code_q <= '0;
            l_gnd_q <= 1'b0;
        end else begin
            l_pow_q <= ladder_q[BIT_L_POWER];
            l_pa_q <= ladder_q[BIT_L_PIN_A];
            l_pb_q <= ladder_q[BIT_L_PIN_B];
            l_low_q <= ladder_q[BIT_L_LOW];
            l_lvl_q <= ladder_q[LEVEL_W-1:0];
            l_code_q <= l_code_d;
            l_gnd_q <= ~ladder_q[BIT_L_POWER] & ladder_q[BIT_L_LOW] &
                (ladder_q[LEVEL_W-1:0] == '0);
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign reg_rdata = rdata_q;
    assign cmp_a_on = a_en_q;
    assign cmp_b_on = b_en_q;
    assign cmp_a_neg_pin_sel = a_neg_q;
    assign cmp_a_pos_pin_sel = a_pos_q;
    assign cmp_b_pos_mux = b_mux_q;
    assign cmp_b_neg_pin_sel = b_neg_q;
    assign cmp_a_pin_out = cmp_if_a.pin_out;
    assign cmp_a_pin_oe_n = cmp_if_a.pin_oe_n;
    assign cmp_b_pin_out = cmp_if_b.pin_out;
    assign cmp_b_pin_oe_n = cmp_if_b.pin_oe_n;
    assign timer_cmp_select = tsel_q;
    assign timer_cmp_clk = tclk_q;
    assign pin_analog_force = force_q;
    assign cmp_wake_set = wake_q;
    assign ladder_power_on = l_pow_q;
    assign ladder_pin_a_drive = l_pa_q;
    assign ladder_pin_b_drive = l_pb_q;
    assign ladder_low_range = l_low_q;
    assign ladder_level = l_lvl_q;
    assign ladder_code = l_code_q;
    assign ladder_grounded = l_gnd_q;

    // =====================================================================
    // Checks
    // =====================================================================
    a_status_read: assert property (
        (reg_rd && reg_addr == ADDR_CMP_A) |=>
        reg_rdata[BIT_RESULT] == $past(cmp_if_a.result))
        else $error("status read does not show result");

    a_timer_src: assert property (
        !ctrl_a_q[BIT_A_TIMER_N] |=>
        (timer_cmp_select && timer_cmp_clk == $past(cmp_if_a.result)))
        else $error("timer not fed from comparator");

    a_enable_out: assert property (
        (reg_wr && reg_addr == ADDR_CMP_A) |-> ##2
        cmp_a_on == $past(reg_wdata[BIT_ON], 2))
        else $error("comparator enable did not follow write");

    a_force_off: assert property (
        (!a_on && !b_on) |=> (pin_analog_force == '0))
        else $error("pin forced analog while off");

    a_b_gated: assert property (
        !b_on |=> (cmp_b_pin_oe_n && cmp_b_neg_pin_sel &&
        cmp_b_pos_mux == BPOS_OWN_PIN && !pin_analog_force[FORCE_B_POS]))
        else $error("comparator b settings act while off");

    // The edge that releases reset still loads the reset code, so the
    // check starts only from an edge at which reset was already low.
    a_ladder_code: assert property (
        !sys_rst |=> ladder_code == ($past(ladder_q[BIT_L_LOW]) ?
        CODE_W'(4 * $past(ladder_q[LEVEL_W-1:0])) :
        CODE_W'(24 + 3 * $past(ladder_q[LEVEL_W-1:0]))))
        else $error("ladder code wrong for range");

    a_ladder_ground: assert property (
        ladder_grounded |-> (ladder_code == '0 && !ladder_power_on))
        else $error("ladder grounded flag inconsistent");

    a_ladder_pin: assert property (
        (reg_wr && reg_addr == ADDR_LADDER) |-> ##2
        (ladder_pin_a_drive == $past(reg_wdata[BIT_L_PIN_A], 2) &&
        ladder_power_on == $past(reg_wdata[BIT_L_POWER], 2)))
        else $error("ladder pin drive did not follow write");

    a_wake_cause: assert property (
        cmp_wake_set |-> $past(armed_q) && $past(!ctrl_a_q[BIT_WAKE_DIS] ||
        !ctrl_b_q[BIT_WAKE_DIS]))
        else $error("wake set without enable or latch");
endmodule : cvr_ctrl

// >>> rtl/cvr_pkg.sv
// Purpose: Shared constants for the comparator and reference control block.
// Assumes: Byte-wide registers reached over a plain strobe port.
// Notes: Bit positions are common to both comparator control registers, except bit 4: timer select on A, positive-input alternate on B.
package cvr_pkg;
    // =====================================================================
    // Register map
    // =====================================================================
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CMP_A = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_CMP_B = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_LADDER = 2'h2;
    localparam logic [DATA_W-1:0] RST_CMP = 8'hff;
    localparam logic [DATA_W-1:0] RST_LADDER = 8'h1f;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

    // =====================================================================
    // Comparator control fields
    // =====================================================================
    localparam int BIT_RESULT = 7;
    localparam int BIT_ROUTE_N = 6;
    localparam int BIT_NONINV = 5;
    localparam int BIT_A_TIMER_N = 4;
    localparam int BIT_B_POS_ALT = 4;
    localparam int BIT_ON = 3;
    localparam int BIT_NEG_SEL = 2;
    localparam int BIT_POS_SEL = 1;
    localparam int BIT_WAKE_DIS = 0;

    // =====================================================================
    // Reference ladder fields and scaling, in 96ths of supply
    // =====================================================================
    localparam int BIT_L_POWER = 7;
    localparam int BIT_L_PIN_A = 6;
    localparam int BIT_L_PIN_B = 5;
    localparam int BIT_L_LOW = 4;
    localparam int LEVEL_W = 4;
    localparam int CODE_W = 7;
    localparam logic [CODE_W-1:0] LADDER_LOW_STEP = 7'h04;
    localparam logic [CODE_W-1:0] LADDER_HIGH_BASE = 7'h18;
    localparam logic [CODE_W-1:0] LADDER_HIGH_STEP = 7'h03;

    // =====================================================================
    // Analog pin override indices and comparator B positive mux
    // =====================================================================
    localparam int FORCE_W = 4;
    localparam int FORCE_A_POS = 0;
    localparam int FORCE_A_NEG = 1;
    localparam int FORCE_B_POS = 2;
    localparam int FORCE_B_NEG = 3;

    typedef enum logic [1:0] {
        BPOS_OWN_PIN = 2'h0,
        BPOS_A_POS_PIN = 2'h1,
        BPOS_B_NEG_PIN = 2'h3
    } cvr_bpos_t;
endpackage : cvr_pkg

// >>> tb/cvr_analog_model.sv
// Purpose: Behavioural comparators and input muxes facing the block.
// Assumes: Levels are codes in 192ths of supply; ladder codes are 96ths.
// Notes: An idle comparator toggles, though no check verifies that a result holds.
module cvr_analog_model #(
    parameter logic [7:0] FIXED_V = 8'h3a
) (
    input wire logic core_clk,
    input wire logic a_on,
    input wire logic b_on,
    input wire logic a_neg_sel,
    input wire logic a_pos_sel,
    input wire logic [1:0] b_pos_mux,
    input wire logic b_neg_sel,
    input wire logic [6:0] ladder_code,
    input wire logic [7:0] v_a_pos,
    input wire logic [7:0] v_a_neg,
    input wire logic [7:0] v_b_pos,
    input wire logic [7:0] v_b_neg,
    output logic raw_a,
    output logic raw_b
);
    logic [7:0] a_p, a_n, b_p, b_n;
    logic idle = 1'h0;

    always_ff @(posedge core_clk) begin
        idle <= ~idle;
    end

    always_comb begin
        a_p = a_pos_sel ? v_a_pos : v_a_neg;
        a_n = a_neg_sel ? v_a_neg : FIXED_V;
        case (b_pos_mux)
            2'h1: b_p = v_a_pos;
            2'h3: b_p = v_b_neg;
            default: b_p = v_b_pos;
        endcase
        b_n = b_neg_sel ? v_b_neg : {ladder_code, 1'h0};
        raw_a = a_on ? (a_p > a_n) : idle;
        raw_b = b_on ? (b_p > b_n) : ~idle;
    end
endmodule : cvr_analog_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the comparator and reference block.
// Assumes: Pins sit in distinct odd classes, except v_b_neg sharing class 5 with v_b_pos in the B wake test; references are even.
// Notes: Distinct classes mean no comparison ever meets a tie.
module tb_top
    import cvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================================
    // Signals and instances
    // ====================================================
    localparam logic [7:0] FIXED_BAND = 8'h3a;
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [ADDR_W-1:0] reg_addr = 2'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic cmp_a_raw, cmp_b_raw, cmp_a_on, cmp_b_on, cmp_a_neg_pin_sel;
    logic cmp_a_pos_pin_sel, cmp_b_neg_pin_sel, cmp_a_pin_out;
    logic cmp_a_pin_oe_n, cmp_b_pin_out, cmp_b_pin_oe_n, timer_cmp_select;
    logic timer_cmp_clk, cmp_wake_set, ladder_power_on, ladder_pin_a_drive;
    logic ladder_pin_b_drive, ladder_low_range, ladder_grounded;
    logic [1:0] cmp_b_pos_mux;
    logic [FORCE_W-1:0] pin_analog_force;
    logic [LEVEL_W-1:0] ladder_level;
    logic [CODE_W-1:0] ladder_code;
    logic [7:0] v_a_pos = 8'hf1;
    logic [7:0] v_a_neg = 8'h03;
    logic [7:0] v_b_pos = 8'hf5;
    logic [7:0] v_b_neg = 8'h07;
    int num_errors = 0;
    int total_checks = 0;

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    cvr_ctrl DUT (
        .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cmp_a_raw, .cmp_b_raw, .cmp_a_on, .cmp_b_on,
        .cmp_a_neg_pin_sel, .cmp_a_pos_pin_sel, .cmp_b_pos_mux,
        .cmp_b_neg_pin_sel, .cmp_a_pin_out, .cmp_a_pin_oe_n, .cmp_b_pin_out,
        .cmp_b_pin_oe_n, .timer_cmp_select, .timer_cmp_clk,
        .pin_analog_force, .cmp_wake_set, .ladder_power_on,
        .ladder_pin_a_drive, .ladder_pin_b_drive, .ladder_low_range,
        .ladder_level, .ladder_code, .ladder_grounded
    );
    cvr_analog_model #(.FIXED_V(FIXED_BAND)) analog (
        .core_clk, .a_on(cmp_a_on), .b_on(cmp_b_on),
        .a_neg_sel(cmp_a_neg_pin_sel), .a_pos_sel(cmp_a_pos_pin_sel),
        .b_pos_mux(cmp_b_pos_mux), .b_neg_sel(cmp_b_neg_pin_sel),
        .ladder_code, .v_a_pos, .v_a_neg, .v_b_pos, .v_b_neg,
        .raw_a(cmp_a_raw), .raw_b(cmp_b_raw)
    );
    // ====================================================
    // Expectations, bus tasks and report
    // ====================================================
    function automatic logic [6:0] lad_exp(input logic [7:0] l);
        return l[4] ? 7'(l[3:0]) * 7'h04 : 7'h18 + 7'(l[3:0]) * 7'h03;
    endfunction : lad_exp

    function automatic logic exp_a(input logic [7:0] c);
        logic [7:0] p, n;
        p = c[1] ? v_a_pos : v_a_neg;
        n = c[2] ? v_a_neg : FIXED_BAND;
        return (p > n) ~^ c[5];
    endfunction : exp_a

    function automatic logic exp_b(input logic [7:0] c, input logic [7:0] l);
        logic [7:0] p, n;
        p = c[1] ? v_b_pos : (c[4] ? v_a_pos : v_b_neg);
        n = c[2] ? v_b_neg : {lad_exp(l), 1'h0};
        return (p > n) ~^ c[5];
    endfunction : exp_b

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(d, e);
    endtask : rd_chk

    task automatic settle;
        repeat (8) @(posedge core_clk);
        #1;
    endtask : settle

    // Counts wake pulses over a bounded span; one pulse must be one cycle.
    task automatic wake_count(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        repeat (12) begin
            @(posedge core_clk);
            #1;
            if (cmp_wake_set === 1'h1) n++;
        end
        check(n, e);
    endtask : wake_count

    task automatic reset_and_check;
        @(posedge core_clk);
        sys_rst <= 1'h1;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'h0;
        settle();
        check(8'({cmp_a_on, cmp_a_pin_oe_n, cmp_b_pin_oe_n, timer_cmp_select,
            pin_analog_force}), 8'hef);
        check(8'(ladder_code), 8'(lad_exp(RST_LADDER)));
        wr(2'h3, 8'h00);
        rd_chk(ADDR_CMP_A, RST_CMP);
        rd_chk(ADDR_CMP_B, RST_CMP);
        rd_chk(ADDR_LADDER, RST_LADDER);
        rd_chk(2'h3, RD_UNMAPPED);
    endtask : reset_and_check

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #4000000;
        num_errors++;
        tally_and_finish();
    end
    // ====================================================
    // Main sequence
    // ====================================================
    initial begin
        logic [7:0] d, ca, cb, lad;
        logic [31:0] r;
        r = $urandom(26);
        reset_and_check();
        for (int i = 0; i < 32; i++) begin
            lad = {3'($urandom), 5'(i)};
            if (i == 16) lad[7] = 1'h0;
            wr(ADDR_LADDER, lad);
            settle();
            check(8'(ladder_code), 8'(lad_exp(lad)));
            check({ladder_power_on, ladder_pin_a_drive, ladder_pin_b_drive,
                ladder_low_range, ladder_level}, lad);
            check(8'(ladder_grounded), 8'(!lad[7] && lad[4:0] == 5'h10));
            rd_chk(ADDR_LADDER, lad);
        end
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            ca = r[7:0] | 8'h08;
            cb = r[15:8] | 8'h08;
            lad = r[23:16];
            if (!ca[1]) ca[2] = 1'h0;
            if (!cb[1] && !cb[4]) cb[2] = 1'h0;
            r = $urandom;
            v_a_pos = {r[4:0], 3'h1};
            v_a_neg = {r[9:5], 3'h3};
            v_b_pos = {r[14:10], 3'h5};
            v_b_neg = {r[19:15], 3'h7};
            wr(ADDR_CMP_A, ca);
            wr(ADDR_CMP_B, cb);
            wr(ADDR_LADDER, lad);
            settle();
            check(8'({cmp_a_pin_oe_n, cmp_a_pin_out, timer_cmp_clk,
                timer_cmp_select, cmp_a_neg_pin_sel, cmp_a_pos_pin_sel,
                cmp_a_on}), 8'({ca[6], exp_a(ca), exp_a(ca), ~ca[4], ca[2],
                ca[1], 1'h1}));
            check(8'({cmp_b_pin_oe_n, cmp_b_pin_out, cmp_b_neg_pin_sel,
                cmp_b_on}), 8'({cb[6], exp_b(cb, lad), cb[2], 1'h1}));
            check(8'(cmp_b_pos_mux), 8'(cb[1] ? BPOS_OWN_PIN : cb[4] ?
                BPOS_A_POS_PIN : BPOS_B_NEG_PIN));
            check(8'(pin_analog_force), 8'({cb[2] | (~cb[1] & ~cb[4]), cb[1],
                ca[2] | ~ca[1], ca[1] | (~cb[1] & cb[4])}));
            rd_chk(ADDR_CMP_A, {exp_a(ca), ca[6:0]});
            rd_chk(ADDR_CMP_B, {exp_b(cb, lad), cb[6:0]});
        end
        wr(ADDR_CMP_A, 8'h77);
        wr(ADDR_CMP_B, 8'h02);
        settle();
        check(8'({cmp_a_on, cmp_b_on, cmp_a_pin_oe_n, cmp_b_pin_oe_n,
            pin_analog_force}), 8'h30);
        check(8'({cmp_b_pos_mux, cmp_b_neg_pin_sel}), 8'h01);
        v_a_pos = 8'hf1;
        v_a_neg = 8'h03;
        wr(ADDR_CMP_A, 8'h7e);
        settle();
        rd(ADDR_CMP_A, d);
        v_a_neg = 8'hfb;
        wake_count(8'h01);
        wr(ADDR_CMP_A, 8'h7f);
        settle();
        rd(ADDR_CMP_A, d);
        v_a_neg = 8'h03;
        wake_count(8'h00);
        v_b_pos = 8'hf5;
        v_b_neg = 8'h07;
        wr(ADDR_CMP_B, 8'h6e);
        settle();
        rd(ADDR_CMP_B, d);
        v_b_neg = 8'hfd;
        wake_count(8'h01);
        v_b_neg = 8'h07;
        reset_and_check();
        tally_and_finish();
    end
endmodule : tb_top
